// *** rtl/idi_map.svh ***
`ifndef IDI_MAP_SVH
`define IDI_MAP_SVH

// ----------------------------------------------------------------------
// Register indices; byte address is four times the index.
// ----------------------------------------------------------------------
`define IDI_IDX_ANG_Y_LOW 8'h28
`define IDI_IDX_ANG_Y_HIGH 8'h2a
`define IDI_IDX_ANG_Z_LOW 8'h2c
`define IDI_IDX_ANG_Z_HIGH 8'h2e
`define IDI_IDX_VEL_X_LOW 8'h30
`define IDI_IDX_VEL_X_HIGH 8'h32
`define IDI_IDX_DECIMATION 8'h64
`define IDI_IDX_CONTROL 8'h70
`define IDI_IDX_STATUS 8'h72

// ----------------------------------------------------------------------
// Reset values and fields.
// ----------------------------------------------------------------------
`define IDI_DEC_RESET 16'h0000
`define IDI_CTRL_EN_RESET 1'b1
`define IDI_CTRL_EN_BIT 0
`define IDI_ADDR_HI_ZERO 2'b00

// ----------------------------------------------------------------------
// Channels, scaling and sizing.
// ----------------------------------------------------------------------
`define IDI_NCH 3
`define IDI_CH_ANG_Y 0
`define IDI_CH_ANG_Z 1
`define IDI_CH_VEL_X 2
`define IDI_OUT_SHIFT 4
`define IDI_RES_MAX 40'sh007fffffff
`define IDI_RES_MIN 40'shff80000000
`define IDI_RES_MOST_NEG 32'h80000000
`define IDI_FS_SPS 2000
`define IDI_FIFO_DEPTH 8
`define IDI_FIFO_WIDTH 48
`define IDI_RESP_OKAY 2'b00
`define IDI_RESP_SLVERR 2'b10

`endif

// *** rtl/idi_pkg.sv ***
package idi_pkg;

  typedef logic signed [39:0] idi_acc_t;

  typedef struct packed {
    logic aw_have;
    logic [11:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] dec;
    logic enable;
    logic [15:0] cnt;
    logic [2:0][39:0] acc;
    logic [2:0][15:0] prev;
    logic [2:0][31:0] res;
    logic [15:0] upd_cnt;
    logic drdy;
  } idi_state_t;

endpackage

// *** rtl/idi_fifo.sv ***
`timescale 1ns/1ps
module idi_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } idi_fifo_state_t;

  idi_fifo_state_t q;
  idi_fifo_state_t d;
  logic full;
  logic empty;

  assign empty = (q.wp == q.rp);
  assign full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = q.mem[q.rp[AW-1:0]];

  always_comb begin
    d = q;
    if (in_valid && !full) begin
      d.mem[q.wp[AW-1:0]] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      d.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// *** rtl/idi_top.sv ***
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
// Contract
// R1: Z delta angle low half is a read-only register at index 0x2c with no defined reset value.
// R2: Z delta angle high half is a read-only register at index 0x2e, twos complement, zero as 0.
// R3: Y delta angle high half uses the same twos complement encoding with zero as 0.
// R4: Each axis high register holds the upper and low the lower half of one 32-bit result.
// R5: Each delta velocity axis has exactly one low and one high output register.
// R6: Delta velocity sums each sample plus its predecessor over D samples, scaled by 1/(2fs).
// R7: D is the decimation setting plus one; one result per D samples, the sum restarting each time.
// R8: Each delta velocity result is the change since the previous update, not absolute velocity.
// R9: With the internal sample clock the integration assumes a nominal 2000 SPS.
// R10: The host may measure data ready at decimation 0 and rescale results by 2000 over that rate.
// R11: X delta velocity low half is a read-only register at index 0x30 with no defined reset value.
// R12: X delta velocity high half is a read-only register at index 0x32, twos complement, zero 0.
// R13: Delta angle uses the same trapezoidal integration of rate samples over D samples.
// R14: Low and high halves of an axis update together from the same result.

`include "idi_map.svh"

module idi_top
  import idi_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sample stream
  input wire logic smp_valid,
  output logic smp_ready,
  input wire logic [15:0] rate_y,
  input wire logic [15:0] rate_z,
  input wire logic [15:0] accel_x,
  // Data ready
  output logic data_ready_pin,
  // Write address channel
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // --------------------------------------------------------------------
  // State and sample buffer.
  // --------------------------------------------------------------------
  idi_state_t q;
  idi_state_t d;
  logic fifo_valid;
  logic fifo_ready;
  logic [`IDI_FIFO_WIDTH-1:0] fifo_data;
  logic pop;

  idi_fifo #(
    .WIDTH(`IDI_FIFO_WIDTH),
    .DEPTH(`IDI_FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(smp_valid),
    .in_ready(smp_ready),
    .in_data({accel_x, rate_z, rate_y}),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  // Draining stalls while integration is disabled, so the buffer fills.
  assign fifo_ready = q.enable;
  assign pop = fifo_valid && q.enable;

  // --------------------------------------------------------------------
  // Decoding helpers.
  // --------------------------------------------------------------------
  function automatic logic [7:0] word_index(input logic [11:0] addr);
    word_index = addr[9:2];
  endfunction

  function automatic logic is_mapped(input logic [11:0] addr);
    logic [7:0] idx;
    idx = word_index(addr);
    is_mapped = 1'b0;
    if (addr[11:10] == `IDI_ADDR_HI_ZERO) begin
      unique case (idx)
        `IDI_IDX_ANG_Y_LOW, `IDI_IDX_ANG_Y_HIGH,
        `IDI_IDX_ANG_Z_LOW, `IDI_IDX_ANG_Z_HIGH,
        `IDI_IDX_VEL_X_LOW, `IDI_IDX_VEL_X_HIGH,
        `IDI_IDX_DECIMATION, `IDI_IDX_CONTROL, `IDI_IDX_STATUS: begin
          is_mapped = 1'b1;
        end
        default: begin
          is_mapped = 1'b0;
        end
      endcase
    end
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction

  // Signed saturation keeps overflow at full scale instead of wrapping.
  function automatic logic [31:0] sat32(input idi_acc_t v);
    if (v > `IDI_RES_MAX) begin
      sat32 = 32'(`IDI_RES_MAX);
    end else if (v < `IDI_RES_MIN) begin
      sat32 = `IDI_RES_MOST_NEG; // R4
    end else begin
      sat32 = v[31:0];
    end
  endfunction

  function automatic logic [31:0] read_word(input logic [11:0] addr);
    logic [15:0] val;
    val = 16'h0000;
    if (addr[11:10] == `IDI_ADDR_HI_ZERO) begin
      unique case (word_index(addr))
        `IDI_IDX_ANG_Y_LOW: val = q.res[`IDI_CH_ANG_Y][15:0]; // R4
        `IDI_IDX_ANG_Y_HIGH: val = q.res[`IDI_CH_ANG_Y][31:16]; // R3
        `IDI_IDX_ANG_Z_LOW: val = q.res[`IDI_CH_ANG_Z][15:0]; // R1
        `IDI_IDX_ANG_Z_HIGH: val = q.res[`IDI_CH_ANG_Z][31:16]; // R2
        `IDI_IDX_VEL_X_LOW: val = q.res[`IDI_CH_VEL_X][15:0]; // R11
        `IDI_IDX_VEL_X_HIGH: val = q.res[`IDI_CH_VEL_X][31:16]; // R12
        `IDI_IDX_DECIMATION: val = q.dec;
        `IDI_IDX_CONTROL: val[`IDI_CTRL_EN_BIT] = q.enable;
        `IDI_IDX_STATUS: val = q.upd_cnt;
        default: val = 16'h0000;
      endcase
    end
    read_word = {16'h0000, val};
  endfunction

  // --------------------------------------------------------------------
  // Port drive.
  // --------------------------------------------------------------------
  assign s_axi_awready = !q.aw_have;
  assign s_axi_wready = !q.w_have;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign data_ready_pin = q.drdy;

  // --------------------------------------------------------------------
  // Next state.
  // --------------------------------------------------------------------
  always_comb begin
    logic [7:0] widx;
    logic [15:0] wval;
    logic last;
    idi_acc_t cur;
    idi_acc_t term;
    idi_acc_t sum;
    widx = 8'h00;
    wval = 16'h0000;
    last = 1'b0;
    cur = '0;
    term = '0;
    sum = '0;
    d = q;
    d.drdy = 1'b0;

    // Write address and data are taken in either order.
    if (s_axi_awvalid && !q.aw_have) begin
      d.aw_have = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_have) begin
      d.w_have = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end else if (q.aw_have && q.w_have && !q.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = is_mapped(q.aw_addr) ? `IDI_RESP_OKAY : `IDI_RESP_SLVERR;
      widx = word_index(q.aw_addr);
      if (is_mapped(q.aw_addr) && widx == `IDI_IDX_DECIMATION) begin
        d.dec = merge16(q.dec, q.w_data, q.w_strb);
      end
      if (is_mapped(q.aw_addr) && widx == `IDI_IDX_CONTROL) begin
        wval = merge16({15'h0000, q.enable}, q.w_data, q.w_strb);
        d.enable = wval[`IDI_CTRL_EN_BIT];
      end
    end

    // Read answer is registered one cycle after the address is taken.
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rdata = read_word(s_axi_araddr);
      d.rresp = is_mapped(s_axi_araddr) ? `IDI_RESP_OKAY : `IDI_RESP_SLVERR;
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // Trapezoidal integration of each channel over D samples.
    if (pop) begin
      last = (q.cnt >= q.dec); // R7
      for (int ch = 0; ch < `IDI_NCH; ch++) begin
        cur = idi_acc_t'($signed(fifo_data[ch*16 +: 16]));
        term = cur + idi_acc_t'($signed(q.prev[ch])); // R6 R13
        sum = q.acc[ch] + term;
        d.prev[ch] = fifo_data[ch*16 +: 16];
        if (last) begin
          // The 1/(2fs) factor is a fixed binary weight of the output LSB.
          d.res[ch] = sat32(sum <<< `IDI_OUT_SHIFT); // R9 R14
          d.acc[ch] = '0; // R8
        end else begin
          d.acc[ch] = sum;
        end
      end
      if (last) begin
        d.cnt = 16'h0000; // R7
        d.upd_cnt = q.upd_cnt + 16'h0001;
        d.drdy = 1'b1; // R10
      end else begin
        d.cnt = q.cnt + 16'h0001;
      end
    end
  end

  // --------------------------------------------------------------------
  // State register.
  // --------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.dec <= `IDI_DEC_RESET;
      q.enable <= `IDI_CTRL_EN_RESET;
    end else begin
      q <= d; // R5
    end
  end

endmodule

// *** test/idi_properties.sv ***
`timescale 1ns/1ps
`include "idi_map.svh"
module idi_properties (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Watched ports
  input wire logic data_ready_pin,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_drdy_one_cycle: assert property (data_ready_pin |=> !data_ready_pin)
    else $error("data ready wider than one cycle");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  a_addr_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second address taken");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_unmapped_slverr: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 12'h004 |=> s_axi_rresp == `IDI_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("hole read not refused");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read half not zero");
endmodule
bind idi_top idi_properties u_props (.aclk, .aresetn, .data_ready_pin, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// *** test/idi_host.sv ***
`timescale 1ns/1ps
module idi_host (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read channels
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
  end
  // Released payloads show the inverse of their last value.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, td;
    logic sa, sd, sb;
    ta = 1'b0;
    td = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && td)) begin
      @(negedge aclk);
      sa = s_axi_awready;
      sd = s_axi_wready;
      @(posedge aclk);
      if (!ta && sa) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (!td && sd) begin
        td = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    do begin
      @(negedge aclk);
      sb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
    end while (sb !== 1'b1);
  endtask
  // Handshake inputs are sampled mid-cycle, where they equal their value at the next edge.
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic s;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      s = s_axi_arready;
      @(posedge aclk);
    end while (s !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do begin
      @(negedge aclk);
      s = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
    end while (s !== 1'b1);
  endtask
endmodule

// *** test/idi_top_test.sv ***
`timescale 1ns/1ps
`include "idi_map.svh"
module idi_top_test;
  logic aclk, aresetn, smp_valid, smp_ready, data_ready_pin;
  logic [15:0] rate_y, rate_z, accel_x;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_mismatch, tests_run, seed, n_upd, n_drdy;
  longint acc[3];
  logic signed [15:0] prv[3];
  localparam logic [11:0] addr_dec = 12'(`IDI_IDX_DECIMATION * 4);
  localparam logic [11:0] addr_ctl = 12'(`IDI_IDX_CONTROL * 4);
  localparam logic [11:0] addr_sts = 12'(`IDI_IDX_STATUS * 4);
  idi_top DUT (.aclk, .aresetn, .smp_valid, .smp_ready, .rate_y, .rate_z, .accel_x,
    .data_ready_pin, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  idi_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (data_ready_pin === 1'b1) begin
      n_drdy++;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("compares %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Trapezoid sum scaled by the output shift, clipped to 32 bits.
  function automatic logic [31:0] sat(input longint s);
    longint t;
    t = s <<< `IDI_OUT_SHIFT;
    if (t > 64'sh7fffffff) return 32'h7fffffff;
    if (t < -64'sh80000000) return `IDI_RES_MOST_NEG;
    return t[31:0];
  endfunction
  task automatic push(input logic [47:0] w);
    logic signed [15:0] s[3];
    logic rdy;
    s = '{w[47:32], w[31:16], w[15:0]};
    for (int c = 0; c < 3; c++) begin
      acc[c] += s[c] + prv[c];
      prv[c] = s[c];
    end
    smp_valid <= 1'b1;
    {rate_y, rate_z, accel_x} <= w;
    do begin
      @(negedge aclk);
      rdy = smp_ready;
      @(posedge aclk);
    end while (rdy !== 1'b1);
  endtask
  task automatic frame(input int d, input bit stall, input logic [47:0] fix);
    logic [31:0] e;
    int k;
    host.wr(addr_dec, 32'(d - 1), r);
    if (stall) host.wr(addr_ctl, 32'h0, r);
    for (int i = 0; i < d; i++) push(fix === 48'h0 ? 48'({$random(seed), $random(seed)}) : fix);
    smp_valid <= 1'b0;
    if (stall) begin
      @(posedge aclk);
      check(32'(smp_ready), 32'h0);
      host.wr(addr_ctl, 32'h1, r);
    end
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (data_ready_pin !== 1'b1 && k < 40);
    check(32'(data_ready_pin), 32'h1);
    n_upd++;
    for (int c = 0; c < 3; c++) begin
      e = sat(acc[c]);
      acc[c] = 0;
      host.rd(12'(`IDI_IDX_ANG_Y_LOW * 4 + 16 * c), v, r);
      check(v, {16'h0, e[15:0]});
      host.rd(12'(`IDI_IDX_ANG_Y_HIGH * 4 + 16 * c), v, r);
      check(v, {16'h0, e[31:16]});
    end
    host.rd(addr_dec, v, r);
    check(v, 32'(d - 1));
  endtask
  initial begin
    seed = 45;
    aresetn = 1'b0;
    smp_valid = 1'b0;
    {rate_y, rate_z, accel_x} = '0;
    {n_mismatch, tests_run, n_upd} = '0;
    acc = '{0, 0, 0};
    prv = '{0, 0, 0};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    host.rd(12'(`IDI_IDX_ANG_Z_HIGH * 4), v, r);
    check(v, 32'h0);
    host.rd(12'h004, v, r);
    check(32'(r), 32'(`IDI_RESP_SLVERR));
    host.wr(12'h004, 32'h1, r);
    check(32'(r), 32'(`IDI_RESP_SLVERR));
    host.wr(12'(`IDI_IDX_VEL_X_HIGH * 4), 32'h1234, r);
    check(32'(r), 32'(`IDI_RESP_OKAY));
    host.rd(12'(`IDI_IDX_VEL_X_HIGH * 4), v, r);
    check(v, 32'h0);
    frame(1, 0, 48'h0);
    frame(1, 0, 48'h0);
    frame(8, 1, 48'h0);
    frame(8, 0, {3{16'h7fff}});
    frame(8, 0, {3{16'h8000}});
    for (int i = 0; i < 4; i++) frame(2 + ($random(seed) & 3), 0, 48'h0);
    host.rd(addr_sts, v, r);
    check(v, 32'(n_upd));
    check(32'(n_drdy), 32'(n_upd));
    summarize();
  end
  initial begin
    #500000;
    n_mismatch++;
    summarize();
  end
endmodule
